/* File: design/trigger_arm_pkg.sv */
// constants and types of the trigger arm and sample sequencer
package trigger_arm_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int MIN_SPACING_DCV_NS = 10000;
   localparam int MIN_SPACING_DIRECT_NS = 20000;
   localparam int MIN_SPACING_SUB_NS = 10;
   // spacing is held in clock ticks; least times round up
   localparam int MIN_TICKS_DCV = (MIN_SPACING_DCV_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MIN_TICKS_DIRECT =
      (MIN_SPACING_DIRECT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MIN_TICKS_SUB = (MIN_SPACING_SUB_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int POWER_ON_SPACING_NS = 100;
   localparam int DEFAULT_SPACING_NS = 20000;
   localparam int POWER_ON_TICKS = POWER_ON_SPACING_NS / CLOCK_PERIOD_NS;
   localparam int DEFAULT_TICKS = DEFAULT_SPACING_NS / CLOCK_PERIOD_NS;

   // ---------------------------------------------------------------
   // widths, ranges and reset values
   // ---------------------------------------------------------------
   localparam int INTERVAL_W = 40;
   localparam int SAMPLES_W = 24;
   localparam int ARMS_W = 32;
   localparam logic [SAMPLES_W-1:0] SAMPLES_MAX = 24'hFED260;
   localparam logic [SAMPLES_W-1:0] SAMPLES_RESET = 24'h000400;
   localparam logic [ARMS_W-1:0] ARMS_MAX = 32'h7D2B7500;

   // ---------------------------------------------------------------
   // arm event codes as returned by the arm query
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ARM_AUTO = 3'h1,
      ARM_EXT = 3'h2,
      ARM_SINGLE = 3'h3,
      ARM_HOLD = 3'h4,
      ARM_DATA_REQ = 3'h5
   } arm_event_t;
   localparam arm_event_t ARM_RESET = ARM_AUTO;

   // measurement functions
   typedef enum logic [2:0] {
      FUNC_DCV = 3'h0,
      FUNC_DIRECT = 3'h1,
      FUNC_SUB = 3'h2,
      FUNC_ACV = 3'h3,
      FUNC_ACDCV = 3'h4,
      FUNC_FREQ = 3'h5,
      FUNC_PERIOD = 3'h6,
      FUNC_OTHER = 3'h7
   } func_t;

   // ac method setting
   typedef enum logic [1:0] {
      AC_ANALOG = 2'h0,
      AC_SYNC = 2'h1,
      AC_RANDOM = 2'h2
   } ac_method_t;
endpackage : trigger_arm_pkg

/* File: design/trigger_arm_sample_sequencer.sv */
// arm, trigger and sample sequencer with interval-timed sample setup
// How it works
// - sample count accepted 1 to 1.67E+7; 1024 after power-on and preset.
// - a sweep command raises spacing to at least 10us DC volts, 20us direct, 10ns sub-sampling.
// - sweep and readings-per-event setups share state; the latest command wins.
// - a sweep setup forces the sample event to the interval timer.
// - reset and preset select readings-per-event; sweep power-on values serve sub-sampling.
// - interval sampling refused for sync or random AC, frequency and period.
// - autoranging suspended while interval-timed sampling is active.
// - sweep query yields spacing first, then sample count.
// - external arm selection arms on a falling edge at the trigger input.
// - selecting external arm clears the stored trigger when latching is on.
// - single-shot arm arms once on the command, then falls to hold.
// - data-request arm needs empty output buffer, empty memory and a request.
// - repeat count only with single-shot, 0 to 2.1E+9; 0 and 1 mean one.
// - counts above one give that many arms, one per cycle, then hold.
// - except sub-sampling, order is arm, then trigger, then sample.
// - an arm only enables the trigger; it never starts a measurement.
// - multiple arming holds the instrument bus until all cycles finish.
// - with the command input buffer on, multiple arming does not hold the bus.
// - arm query returns the selected arm event.
// - latching on: first trigger during a reading is kept, used afterwards, no error.
`timescale 1ns/100ps
`default_nettype none
module trigger_arm_sample_sequencer #(
   parameter int INTERVAL_W = trigger_arm_pkg::INTERVAL_W,
   parameter int SAMPLES_W = trigger_arm_pkg::SAMPLES_W,
   parameter int ARMS_W = trigger_arm_pkg::ARMS_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic preset_i,
   input wire logic arm_cmd_i,
   input wire trigger_arm_pkg::arm_event_t arm_event_select_i,
   input wire logic [ARMS_W-1:0] arm_count_i,
   input wire logic sweep_cmd_i,
   input wire logic [INTERVAL_W-1:0] sweep_interval_i,
   input wire logic [SAMPLES_W-1:0] sweep_samples_i,
   input wire logic readings_per_event_setup_i,
   input wire logic readings_timer_i,
   input wire trigger_arm_pkg::func_t func_i,
   input wire trigger_arm_pkg::ac_method_t ac_method_setting_i,
   input wire logic external_trigger_latch_enable_i,
   input wire logic latch_clear_i,
   input wire logic ext_trig_i,
   input wire logic out_buf_empty_i,
   input wire logic mem_empty_i,
   input wire logic data_req_i,
   input wire logic input_buffer_en_i,
   input wire logic trigger_event_i,
   input wire logic sample_event_i,
   input wire logic reading_busy_i,
   input wire logic cycle_done_i,
   output logic armed_o,
   output logic measure_go_o,
   output trigger_arm_pkg::arm_event_t arm_event_o,
   output logic sweep_mode_o,
   output logic sample_timer_sel_o,
   output logic autorange_suspend_o,
   output logic [INTERVAL_W-1:0] sweep_interval_o,
   output logic [SAMPLES_W-1:0] sweep_samples_o,
   output logic bus_hold_o,
   output logic cmd_error_o,
   output logic too_fast_o,
   output logic ext_stored_o
);
   import trigger_arm_pkg::*;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (SAMPLES_W < 24 || ARMS_W < 31 || INTERVAL_W < 16) begin : g_bad_width
      $error("field widths too narrow for the documented ranges");
   end

   typedef enum logic [3:0] {
      ST_WAIT_ARM = 4'h1,
      ST_ARMED = 4'h2,
      ST_TRIGGERED = 4'h4,
      ST_MEASURE = 4'h8
   } seq_state_t;

   seq_state_t state_q;
   arm_event_t arm_event_q;
   logic ext_meta_q, ext_sync_q, ext_prev_q;
   logic ext_fall;
   logic ext_latch_q;
   logic ext_hit;
   logic [ARMS_W-1:0] arms_left_q;
   logic multi_q;
   logic arm_ok;
   logic arm_take;
   logic sweep_ok;
   logic sweep_allowed;
   logic [INTERVAL_W-1:0] min_ticks;
   logic subsample;
   logic measure_start;

   // ---------------------------------------------------------------
   // external trigger input: two-stage synchroniser, falling edge
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ext_meta_q <= 1'b1;
         ext_sync_q <= 1'b1;
         ext_prev_q <= 1'b1;
      end else begin
         ext_meta_q <= ext_trig_i;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end
   assign ext_fall = ext_prev_q & ~ext_sync_q;

   // ---------------------------------------------------------------
   // stored external trigger
   // ---------------------------------------------------------------
   // only the first edge during a reading is kept; set beats any clear
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ext_latch_q <= 1'b0;
      end else if (ext_fall && reading_busy_i && external_trigger_latch_enable_i) begin
         ext_latch_q <= 1'b1;
      end else if (latch_clear_i || !external_trigger_latch_enable_i) begin
         ext_latch_q <= 1'b0;
      end else if (arm_cmd_i && arm_event_select_i == ARM_EXT) begin
         ext_latch_q <= 1'b0;
      end else if (ext_hit && ext_latch_q) begin
         ext_latch_q <= 1'b0; // cleared once the reading is over, whether or not an arm waits
      end
   end
   assign ext_stored_o = ext_latch_q;

   // a stored edge counts only once the reading is over
   assign ext_hit = !reading_busy_i && (ext_fall || ext_latch_q);

   // unbuffered edges during a reading are lost and flagged
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         too_fast_o <= 1'b0;
      end else begin
         too_fast_o <= ext_fall && reading_busy_i && !external_trigger_latch_enable_i;
      end
   end

   // ---------------------------------------------------------------
   // arm event selection and repeat count
   // ---------------------------------------------------------------
   // a refused repeat count leaves selection and sequence untouched
   assign arm_take = arm_cmd_i &&
                     !(arm_event_select_i == ARM_SINGLE && arm_count_i > ARMS_MAX);

   always_ff @(posedge clock_i) begin
      if (rst_i || preset_i) begin
         arm_event_q <= ARM_RESET;
         arms_left_q <= '0;
         multi_q <= 1'b0;
      end else if (arm_take) begin
         arm_event_q <= arm_event_select_i;
         if (arm_event_select_i == ARM_SINGLE) begin
            // zero and one both mean a single arm
            arms_left_q <= (arm_count_i == '0) ? ARMS_W'(1) : arm_count_i;
            multi_q <= (arm_count_i > ARMS_W'(1));
         end else begin
            arms_left_q <= '0;
            multi_q <= 1'b0;
         end
      end else if (arm_event_q == ARM_SINGLE) begin
         if (state_q == ST_WAIT_ARM && arms_left_q != '0) begin
            arms_left_q <= arms_left_q - ARMS_W'(1);
         end else if (arms_left_q == '0 && state_q == ST_WAIT_ARM) begin
            arm_event_q <= ARM_HOLD;
            multi_q <= 1'b0;
         end
      end
   end
   assign arm_event_o = arm_event_q;

   // arm condition for each selection
   always_comb begin
      case (arm_event_q)
         ARM_AUTO: arm_ok = 1'b1;
         ARM_EXT: arm_ok = ext_hit;
         ARM_SINGLE: arm_ok = (arms_left_q != '0);
         ARM_DATA_REQ: arm_ok = out_buf_empty_i && mem_empty_i && data_req_i;
         default: arm_ok = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // arm, trigger, sample sequence
   // ---------------------------------------------------------------
   assign subsample = (func_i == FUNC_SUB);
   // sub-sampling goes from arm straight to sampling
   always_ff @(posedge clock_i) begin
      if (rst_i || preset_i) begin
         state_q <= ST_WAIT_ARM;
      end else if (arm_take) begin
         // a new selection drops an old arm, so hold really stops triggering
         state_q <= ST_WAIT_ARM;
      end else begin
         case (state_q)
            ST_WAIT_ARM: begin
               if (arm_ok) begin
                  state_q <= subsample ? ST_TRIGGERED : ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (trigger_event_i) begin
                  state_q <= ST_TRIGGERED;
               end
            end
            ST_TRIGGERED: begin
               if (sample_event_i) begin
                  state_q <= ST_MEASURE;
               end
            end
            ST_MEASURE: begin
               if (cycle_done_i) begin
                  state_q <= ST_WAIT_ARM;
               end
            end
            default: state_q <= ST_WAIT_ARM;
         endcase
      end
   end
   assign measure_start = (state_q == ST_TRIGGERED) && sample_event_i;

   // outputs of the sequence, registered
   always_ff @(posedge clock_i) begin
      if (rst_i || preset_i) begin
         armed_o <= 1'b0;
         measure_go_o <= 1'b0;
      end else begin
         armed_o <= (state_q == ST_ARMED);
         measure_go_o <= measure_start;
      end
   end

   // ---------------------------------------------------------------
   // bus hold during multiple arming
   // ---------------------------------------------------------------
   // the input buffer lets the controller have the bus back at once
   always_ff @(posedge clock_i) begin
      if (rst_i || preset_i) begin
         bus_hold_o <= 1'b0;
      end else begin
         bus_hold_o <= multi_q && !input_buffer_en_i;
      end
   end

   // ---------------------------------------------------------------
   // interval-timed sample setup
   // ---------------------------------------------------------------
   always_comb begin
      case (func_i)
         FUNC_DCV: min_ticks = INTERVAL_W'(MIN_TICKS_DCV);
         FUNC_SUB: min_ticks = INTERVAL_W'(MIN_TICKS_SUB);
         default: min_ticks = INTERVAL_W'(MIN_TICKS_DIRECT);
      endcase
   end

   // sync and random ac, frequency and period have no timed sampling
   assign sweep_allowed = !(((func_i == FUNC_ACV) || (func_i == FUNC_ACDCV)) &&
                            (ac_method_setting_i != AC_ANALOG)) &&
                          (func_i != FUNC_FREQ) && (func_i != FUNC_PERIOD);
   assign sweep_ok = sweep_allowed && (sweep_samples_i != '0) &&
                     (sweep_samples_i <= SAMPLES_MAX);

   // interval below the function's floor is raised to the floor
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sweep_interval_o <= INTERVAL_W'(POWER_ON_TICKS);
         sweep_samples_o <= SAMPLES_W'(SAMPLES_RESET);
      end else if (preset_i) begin
         sweep_interval_o <= INTERVAL_W'(DEFAULT_TICKS);
         sweep_samples_o <= SAMPLES_W'(SAMPLES_RESET);
      end else if (sweep_cmd_i && sweep_ok) begin
         sweep_interval_o <= (sweep_interval_i < min_ticks) ? min_ticks : sweep_interval_i;
         sweep_samples_o <= sweep_samples_i;
      end
   end

   // which setup was written last decides the sampling
   always_ff @(posedge clock_i) begin
      if (rst_i || preset_i) begin
         sweep_mode_o <= 1'b0;
         sample_timer_sel_o <= 1'b0;
         autorange_suspend_o <= 1'b0;
      end else if (sweep_cmd_i && sweep_ok) begin
         sweep_mode_o <= 1'b1;
         sample_timer_sel_o <= 1'b1;
         autorange_suspend_o <= 1'b1;
      end else if (readings_per_event_setup_i) begin
         sweep_mode_o <= 1'b0;
         sample_timer_sel_o <= readings_timer_i;
         autorange_suspend_o <= readings_timer_i;
      end
   end

   // refused commands give a one-cycle error pulse
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cmd_error_o <= 1'b0;
      end else begin
         cmd_error_o <= (sweep_cmd_i && !sweep_ok) ||
                        (arm_cmd_i && arm_event_select_i == ARM_SINGLE && arm_count_i > ARMS_MAX);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i || preset_i);

   AST_SAMPLES_RANGE: assert property (
      sweep_samples_o != '0 && sweep_samples_o <= SAMPLES_MAX)
      else $error("sample count out of range");
   AST_MIN_SPACING: assert property (
      sweep_cmd_i && sweep_ok && func_i == FUNC_DCV |=> sweep_interval_o >= INTERVAL_W'(MIN_TICKS_DCV))
      else $error("spacing below dc floor");
   AST_LAST_WINS: assert property (
      readings_per_event_setup_i && !(sweep_cmd_i && sweep_ok) |=> !sweep_mode_o)
      else $error("readings setup did not take over");
   AST_TIMER_FORCED: assert property (
      sweep_cmd_i && sweep_ok |=> sample_timer_sel_o && autorange_suspend_o)
      else $error("sweep did not select timer");
   AST_SWEEP_REFUSED: assert property (
      sweep_cmd_i && func_i == FUNC_FREQ |=> $stable(sweep_samples_o) && cmd_error_o)
      else $error("sweep accepted for frequency");
   AST_EXT_ARM: assert property (
      state_q == ST_WAIT_ARM && arm_event_q == ARM_EXT && !ext_hit |=> state_q == ST_WAIT_ARM)
      else $error("external arm without edge");
   AST_SINGLE_TO_HOLD: assert property (
      arm_event_q == ARM_SINGLE && arms_left_q == '0 && state_q == ST_WAIT_ARM && !arm_cmd_i
      |=> arm_event_q == ARM_HOLD)
      else $error("single arm did not fall to hold");
   AST_ORDER: assert property (
      measure_go_o |-> $past(state_q) == ST_TRIGGERED)
      else $error("measurement without arm and trigger");
   AST_ARM_NO_START: assert property (
      state_q == ST_ARMED && !trigger_event_i && !arm_cmd_i
      |=> state_q == ST_ARMED ##0 !measure_go_o)
      else $error("arm alone advanced the sequence");
   AST_BUS_HOLD: assert property (
      input_buffer_en_i |=> !bus_hold_o)
      else $error("bus held with input buffer on");
   AST_LATCH_FIRST: assert property (
      ext_fall && reading_busy_i && external_trigger_latch_enable_i |=> ext_latch_q && !too_fast_o)
      else $error("buffered trigger lost or flagged");
endmodule : trigger_arm_sample_sequencer
`default_nettype wire

/* File: tb/ext_trig_source.sv */
// external trigger source driving the ttl trigger pin of the sequencer
`timescale 1ns/100ps
`default_nettype none
module ext_trig_source (
   input wire logic clock_i,
   input wire logic fire_i,
   output logic ext_trig_o
);
   logic [2:0] low_q = 3'h0;

   // one request gives one falling edge, low long enough for the synchroniser
   always_ff @(posedge clock_i) begin
      if (fire_i) begin
         low_q <= 3'h4;
      end else if (low_q != 3'h0) begin
         low_q <= low_q - 3'h1;
      end
   end
   // ttl line idles high, so only the edge into low is an event
   assign ext_trig_o = (low_q == 3'h0);
endmodule : ext_trig_source
`default_nettype wire

/* File: tb/test_trigger_arm_sample_sequencer.sv */
// self-checking bench for the trigger arm and sample sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
`define PULSE(s) begin @(posedge clock); s <= 1'b1; @(posedge clock); s <= 1'b0; end
module test_trigger_arm_sample_sequencer;
   import trigger_arm_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clock, rst, preset, arm_cmd, sweep_cmd, rpe_setup, rpe_timer, latch_en, latch_clear;
   logic ext_trig, fire, obuf_empty, mem_empty, data_req, inbuf_en, trig_ev, samp_ev, busy, done;
   logic armed, go, sweep_mode, timer_sel, ar_susp, bus_hold, cmd_err, too_fast, ext_stored;
   arm_event_t arm_sel, arm_ev;
   logic [ARMS_W-1:0] arm_count;
   logic [INTERVAL_W-1:0] s_interval, interval_q;
   logic [SAMPLES_W-1:0] s_samples, samples_q;
   func_t func;
   ac_method_t ac_method;
   int err_count = 0, n_checks = 0, go_cnt = 0;
   logic err_seen = 1'b0, fast_seen = 1'b0;
   func_t rf[6] = '{FUNC_ACV, FUNC_ACDCV, FUNC_FREQ, FUNC_PERIOD, FUNC_DCV, FUNC_DCV};
   ac_method_t rm[6] = '{AC_SYNC, AC_RANDOM, AC_ANALOG, AC_ANALOG, AC_ANALOG, AC_ANALOG};
   logic [SAMPLES_W-1:0] rn[6] = '{24'h000010, 24'h000010, 24'h000010, 24'h000010, 24'h000000,
      24'hFED261};
   func_t cf[4] = '{FUNC_DCV, FUNC_DIRECT, FUNC_SUB, FUNC_DCV};
   int civ[4] = '{10, 10, 0, 5000};
   int cexp[4] = '{MIN_TICKS_DCV, MIN_TICKS_DIRECT, MIN_TICKS_SUB, 5000};
   arm_event_t codes[4] = '{ARM_AUTO, ARM_EXT, ARM_HOLD, ARM_DATA_REQ};

   trigger_arm_sample_sequencer dut (.clock_i(clock), .rst_i(rst), .preset_i(preset),
      .arm_cmd_i(arm_cmd), .arm_event_select_i(arm_sel), .arm_count_i(arm_count),
      .sweep_cmd_i(sweep_cmd), .sweep_interval_i(s_interval), .sweep_samples_i(s_samples),
      .readings_per_event_setup_i(rpe_setup), .readings_timer_i(rpe_timer), .func_i(func),
      .ac_method_setting_i(ac_method), .external_trigger_latch_enable_i(latch_en),
      .latch_clear_i(latch_clear), .ext_trig_i(ext_trig), .out_buf_empty_i(obuf_empty),
      .mem_empty_i(mem_empty), .data_req_i(data_req), .input_buffer_en_i(inbuf_en),
      .trigger_event_i(trig_ev), .sample_event_i(samp_ev), .reading_busy_i(busy),
      .cycle_done_i(done), .armed_o(armed), .measure_go_o(go), .arm_event_o(arm_ev),
      .sweep_mode_o(sweep_mode), .sample_timer_sel_o(timer_sel), .autorange_suspend_o(ar_susp),
      .sweep_interval_o(interval_q), .sweep_samples_o(samples_q), .bus_hold_o(bus_hold),
      .cmd_error_o(cmd_err), .too_fast_o(too_fast), .ext_stored_o(ext_stored));

   ext_trig_source source (.clock_i(clock), .fire_i(fire), .ext_trig_o(ext_trig));

   // ---------------------------------------------------------------
   // clock, pulse catchers, closing
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // one-cycle outputs are caught here so no check depends on the exact cycle
   always @(posedge clock) begin
      if (go === 1'b1) go_cnt++;
      if (cmd_err === 1'b1) err_seen = 1'b1;
      if (too_fast === 1'b1) fast_seen = 1'b1;
   end
   task stop_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // a hang is cut well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task settle();
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   task arm(input arm_event_t code, input logic [ARMS_W-1:0] cnt);
      @(posedge clock);
      arm_sel <= code;
      arm_count <= cnt;
      arm_cmd <= 1'b1;
      err_seen = 1'b0;
      @(posedge clock);
      arm_cmd <= 1'b0;
      settle();
   endtask : arm
   task sweep(input func_t f, input ac_method_t m, input int iv, input logic [23:0] n);
      @(posedge clock);
      func <= f;
      ac_method <= m;
      s_interval <= INTERVAL_W'(iv);
      s_samples <= n;
      sweep_cmd <= 1'b1;
      err_seen = 1'b0;
      @(posedge clock);
      sweep_cmd <= 1'b0;
      settle();
   endtask : sweep
   // arm wait, then trigger, then sample, then end of the measurement cycle
   task run_cycle(input int exp_go);
      go_cnt = 0;
      repeat (3) @(posedge clock);
      `PULSE(trig_ev)
      `PULSE(samp_ev)
      settle();
      `CHECK("measure start", exp_go, go_cnt)
      `PULSE(done)
      settle();
   endtask : run_cycle
   task ext_edge();
      `PULSE(fire)
      repeat (8) @(posedge clock);
      #1;
   endtask : ext_edge

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, preset, arm_cmd, sweep_cmd, rpe_setup, rpe_timer, latch_en, latch_clear} = '0;
      {fire, obuf_empty, mem_empty, data_req, inbuf_en, trig_ev, samp_ev, busy, done} = '0;
      rst = 1'b1;
      arm_sel = ARM_AUTO;
      arm_count = '0;
      s_interval = '0;
      s_samples = '0;
      func = FUNC_DCV;
      ac_method = AC_ANALOG;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      settle();
      `CHECK("reset arm", ARM_AUTO, arm_ev)
      `CHECK("reset count", SAMPLES_RESET, samples_q)
      `CHECK("reset interval", INTERVAL_W'(POWER_ON_TICKS), interval_q)
      `CHECK("reset mode", 1'b0, sweep_mode)
      sweep(FUNC_DCV, AC_ANALOG, 5000, 24'h000064);
      `CHECK("sweep mode", 1'b1, sweep_mode)
      `CHECK("timer sel", 1'b1, timer_sel)
      `CHECK("autorange", 1'b1, ar_susp)
      `CHECK("query count", 24'h000064, samples_q)
      for (int i = 0; i < 4; i++) begin
         sweep(cf[i], AC_ANALOG, civ[i], 24'hFED260);
         `CHECK("spacing floor", INTERVAL_W'(cexp[i]), interval_q)
         `CHECK("top count", 24'hFED260, samples_q)
      end
      // functions and counts that interval sampling must refuse
      for (int i = 0; i < 6; i++) begin
         sweep(rf[i], rm[i], 3000, rn[i]);
         `CHECK("refused", 1'b1, err_seen)
         `CHECK("kept spacing", INTERVAL_W'(5000), interval_q)
      end
      func <= FUNC_DCV;
      `PULSE(rpe_setup)
      settle();
      `CHECK("readings wins", 1'b0, sweep_mode)
      `CHECK("autorange back", 1'b0, ar_susp)
      sweep(FUNC_DCV, AC_ANALOG, 5000, 24'h000064);
      `PULSE(preset)
      settle();
      `CHECK("preset mode", 1'b0, sweep_mode)
      `CHECK("preset interval", INTERVAL_W'(DEFAULT_TICKS), interval_q)
      `CHECK("preset count", SAMPLES_RESET, samples_q)
      `CHECK("preset arm", ARM_AUTO, arm_ev)
      // a sample before its trigger must not start anything
      go_cnt = 0;
      `PULSE(samp_ev)
      settle();
      `CHECK("sample first", 0, go_cnt)
      run_cycle(1);
      for (int i = 0; i < 4; i++) begin
         arm(codes[i], '0);
         `CHECK("arm query", codes[i], arm_ev)
      end
      arm(ARM_HOLD, '0);
      run_cycle(0);
      {obuf_empty, mem_empty} <= 2'b11;
      arm(ARM_DATA_REQ, '0);
      run_cycle(0);
      {obuf_empty, data_req} <= 2'b01;
      run_cycle(0);
      obuf_empty <= 1'b1;
      run_cycle(1);
      data_req <= 1'b0;
      arm(ARM_EXT, '0);
      run_cycle(0);
      ext_edge();
      `CHECK("ext armed", 1'b1, armed)
      run_cycle(1);
      latch_en <= 1'b1;
      busy <= 1'b1;
      ext_edge();
      `CHECK("stored", 1'b1, ext_stored)
      arm(ARM_EXT, '0);
      `CHECK("select clears", 1'b0, ext_stored)
      ext_edge();
      busy <= 1'b0;
      settle();
      `CHECK("stored used", 1'b1, armed)
      `CHECK("no error", 1'b0, fast_seen)
      run_cycle(1);
      {latch_en, busy} <= 2'b01;
      ext_edge();
      `CHECK("too fast", 1'b1, fast_seen)
      busy <= 1'b0;
      arm(ARM_SINGLE, '0);
      run_cycle(1);
      run_cycle(0);
      `CHECK("single to hold", ARM_HOLD, arm_ev)
      arm(ARM_SINGLE, 32'h7D2B7501);
      `CHECK("count refused", 1'b1, err_seen)
      arm(ARM_SINGLE, 32'h00000003);
      `CHECK("bus held", 1'b1, bus_hold)
      for (int i = 0; i < 3; i++) run_cycle(1);
      settle();
      `CHECK("multi to hold", ARM_HOLD, arm_ev)
      `CHECK("bus free", 1'b0, bus_hold)
      inbuf_en <= 1'b1;
      arm(ARM_SINGLE, 32'h00000002);
      `CHECK("inbuf no hold", 1'b0, bus_hold)
      run_cycle(1);
      run_cycle(1);
      // sub-sampling needs no trigger event between arm and sample
      func <= FUNC_SUB;
      arm(ARM_AUTO, '0);
      go_cnt = 0;
      `PULSE(samp_ev)
      settle();
      `CHECK("sub skips trigger", 1, go_cnt)
      stop_test();
   end
endmodule : test_trigger_arm_sample_sequencer
`default_nettype wire
